//--- rtl/gwbv_top.sv
// APB slave holding the 16-bit scratch word and its byte views
// What this block does
// - swapped view returns word with bytes exchanged
// - swapped view is read only
// - swapped and sign-extended views reset to zero
// - high view reads word bits 15 to 8
// - high view write updates upper byte only
// - high view resets to zero
// - sign view copies low byte, extends bit 7
// - sign view is read only
// - low view write updates lower byte only
// - word is 16 bits, reachable by bytes
`default_nettype none
module gwbv_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // apb response
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    gwbv_pkg::gwbv_apb_req_t req;
    gwbv_pkg::gwbv_apb_rsp_t rsp;
    logic [15:0] scratch_word_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] read_word;
    logic read_only;
    logic refuse;
    logic commit;
    logic wr_full;
    logic wr_low;
    logic wr_high;
    logic [15:0] swap_v;
    logic [7:0] high_v;
    logic [7:0] low_v;
    logic [15:0] sext_v;
    logic [3:0] idx;
    logic aligned;
    logic in_map;
    logic access;
    logic setup;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign idx = req.paddr[5:2];
    // only word-aligned addresses inside the first sixteen words are mapped
    assign aligned = (req.paddr[1:0] == 2'h0) && (req.paddr[11:6] == 6'h00);
    assign setup = req.psel && !req.penable;
    // answer comes one cycle after setup: pready rises in the access phase
    assign access = req.psel && req.penable && pready_reg;
    // a write lands only at the access edge and never in a refused word
    assign commit = access && req.pwrite && !refuse;

    // the two derived views have no write path of their own
    always_comb begin
        read_only = 1'b0;
        case (idx)
            gwbv_pkg::gwbv_idx_swap,
            gwbv_pkg::gwbv_idx_sext: begin
                read_only = 1'b1;
            end
            default: begin
                read_only = 1'b0;
            end
        endcase
    end

    // writes to read-only views or unmapped words are flagged, not stored
    always_comb begin
        refuse = 1'b0;
        if (!in_map) begin
            refuse = 1'b1;
        end else if (req.pwrite && read_only) begin
            refuse = 1'b1;
        end
    end

    always_comb begin
        in_map = 1'b0;
        case (idx)
            gwbv_pkg::gwbv_idx_full,
            gwbv_pkg::gwbv_idx_low,
            gwbv_pkg::gwbv_idx_swap,
            gwbv_pkg::gwbv_idx_high,
            gwbv_pkg::gwbv_idx_sext: begin
                in_map = aligned;
            end
            default: begin
                in_map = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // views
    // ----------------------------------------------------------------
    gwbv_views u_views (
        .scratch_word(scratch_word_reg),
        .swapped_word_view(swap_v),
        .high_byte_view(high_v),
        .low_byte_view(low_v),
        .sign_extended_low_view(sext_v)
    );

    // ----------------------------------------------------------------
    // scratch word write path
    // ----------------------------------------------------------------
    // one decoded strobe per writable view
    always_comb begin
        wr_full = 1'b0;
        wr_low = 1'b0;
        wr_high = 1'b0;
        if (commit) begin
            case (idx)
                gwbv_pkg::gwbv_idx_full: begin
                    wr_full = 1'b1;
                end
                gwbv_pkg::gwbv_idx_low: begin
                    wr_low = 1'b1;
                end
                gwbv_pkg::gwbv_idx_high: begin
                    wr_high = 1'b1;
                end
                default: begin
                    // swapped and sign views never reach the word
                    wr_full = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scratch_word_reg <= gwbv_pkg::gwbv_word_rst;
        end else if (wr_full) begin
            scratch_word_reg <= req.pwdata[15:0];
        end else if (wr_low) begin
            scratch_word_reg[gwbv_pkg::gwbv_lo_lsb +: 8] <= req.pwdata[7:0];
        end else if (wr_high) begin
            scratch_word_reg[gwbv_pkg::gwbv_hi_lsb +: 8] <= req.pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // read data select
    // ----------------------------------------------------------------
    // bits above a view's width read as zero
    always_comb begin
        read_word = gwbv_pkg::gwbv_rdata_rst;
        case (idx)
            gwbv_pkg::gwbv_idx_full: begin
                read_word = {16'h0000, scratch_word_reg};
            end
            gwbv_pkg::gwbv_idx_low: begin
                read_word = {24'h000000, low_v};
            end
            gwbv_pkg::gwbv_idx_swap: begin
                read_word = {16'h0000, swap_v};
            end
            gwbv_pkg::gwbv_idx_high: begin
                read_word = {24'h000000, high_v};
            end
            gwbv_pkg::gwbv_idx_sext: begin
                read_word = {16'h0000, sext_v};
            end
            default: begin
                read_word = gwbv_pkg::gwbv_rdata_rst;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // response
    // ----------------------------------------------------------------
    // ready is a one-cycle pulse after every setup, so no access waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
        end
    end

    // the error bit stands with pready only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            pslverr_reg <= refuse;
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    // read data stands only with pready, so a stale word never leaks out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= gwbv_pkg::gwbv_rdata_rst;
        end else if (setup && !req.pwrite && in_map) begin
            prdata_reg <= read_word;
        end else begin
            prdata_reg <= gwbv_pkg::gwbv_rdata_rst;
        end
    end

    // outputs come straight from the response flops
    assign rsp = '{
        pready: pready_reg,
        pslverr: pslverr_reg,
        prdata: prdata_reg
    };
    assign prdata = rsp.prdata;
    assign pready = rsp.pready;
    assign pslverr = rsp.pslverr;
endmodule : gwbv_top
`default_nettype wire

//--- rtl/gwbv_pkg.sv
// package: register map, reset values and bus carrier types for the scratch word views
`default_nettype none
package gwbv_pkg;
    // printed offsets are indices; byte address is four times the index
    localparam logic [3:0] gwbv_idx_full = 4'h5;
    localparam logic [3:0] gwbv_idx_low = 4'h6;
    localparam logic [3:0] gwbv_idx_swap = 4'h8;
    localparam logic [3:0] gwbv_idx_high = 4'h9;
    localparam logic [3:0] gwbv_idx_sext = 4'ha;
    localparam int gwbv_addr_w = 12;
    localparam logic [15:0] gwbv_word_rst = 16'h0000;
    localparam logic [31:0] gwbv_rdata_rst = 32'h0000_0000;
    localparam int gwbv_lo_lsb = 0;
    localparam int gwbv_hi_lsb = 8;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [gwbv_addr_w-1:0] paddr;
        logic [31:0] pwdata;
    } gwbv_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } gwbv_apb_rsp_t;
endpackage : gwbv_pkg
`default_nettype wire

//--- rtl/gwbv_views.sv
// combinational byte views derived from the stored scratch word
`default_nettype none
module gwbv_views (
    // stored word
    input wire logic [15:0] scratch_word,
    // derived views
    output logic [15:0] swapped_word_view,
    output logic [7:0] high_byte_view,
    output logic [7:0] low_byte_view,
    output logic [15:0] sign_extended_low_view
);
    // no storage here, so every view follows the word without a cycle of lag
    assign swapped_word_view = {scratch_word[7:0], scratch_word[15:8]};
    assign high_byte_view = scratch_word[15:8];
    assign low_byte_view = scratch_word[7:0];
    assign sign_extended_low_view = {{8{scratch_word[7]}}, scratch_word[7:0]};
endmodule : gwbv_views
`default_nettype wire

//--- verif/gwbv_chk.sv
// checker: apb timing and view relations of the scratch word block
`default_nettype none
module gwbv_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] w_reg;
    wire logic rd = pready && !pwrite;
    wire logic wr = pready && pwrite;
    // shadow word follows committed writes only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) w_reg <= 16'h0;
        else if (wr && paddr == 12'h014) w_reg <= pwdata[15:0];
        else if (wr && paddr == 12'h018) w_reg[7:0] <= pwdata[7:0];
        else if (wr && paddr == 12'h024) w_reg[15:8] <= pwdata[7:0];
    end
    sequence s_setup; psel && !penable; endsequence
    a_ready_after: assert property (s_setup |=> pready) else $error("no ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    a_swap_read: assert property (rd && paddr == 12'h020 |->
        prdata == {16'h0, w_reg[7:0], w_reg[15:8]}) else $error("swap");
    a_high_read: assert property (rd && paddr == 12'h024 |->
        prdata == {24'h0, w_reg[15:8]}) else $error("high");
    a_sext_read: assert property (rd && paddr == 12'h028 |->
        prdata == {16'h0, {8{w_reg[7]}}, w_reg[7:0]}) else $error("sext");
    a_full_read: assert property (rd && paddr == 12'h014 |->
        prdata == {16'h0, w_reg}) else $error("full");
    a_low_read: assert property (rd && paddr == 12'h018 |->
        prdata == {24'h0, w_reg[7:0]}) else $error("low");
    a_ro_refused: assert property (wr && (paddr == 12'h020 || paddr == 12'h028) |->
        pslverr) else $error("ro write");
endmodule : gwbv_chk
bind gwbv_top gwbv_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);
`default_nettype wire

//--- verif/gwbv_apb_master.sv
// apb master model standing in for the core datapath
`default_nettype none
module gwbv_apb_master (
    // clock
    input wire logic pclk,
    // request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // response
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d,
                        output logic [32:0] r);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= we;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = {pslverr, prdata};
        psel <= 1'h0;
        penable <= 1'h0;
        // released data must not look like a held value
        pwdata <= ~d;
    endtask : xfer
endmodule : gwbv_apb_master
`default_nettype wire

//--- verif/test_general_word_byte_views.sv
// testbench: scratch word views over apb
`default_nettype none
module test_general_word_byte_views;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #12.5 pclk = ~pclk;
    gwbv_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    gwbv_apb_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic finish_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // read data during a write is unspecified, so writes judge only the error bit
    task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        logic [32:0] r;
        m.xfer(we, a, d, r);
        if (we) r[31:0] = 32'h0;
        cmp_count++;
        if (r !== e) begin
            num_errors++;
            $display("Error addr %h expected %h seen %h", a, e, r);
        end
    endtask : acc
    task automatic reset_views;
        acc(1'h0, 12'h020, 32'h0, 33'h0);
        acc(1'h0, 12'h024, 32'h0, 33'h0);
        acc(1'h0, 12'h028, 32'h0, 33'h0);
    endtask : reset_views
    task automatic byte_writes;
        acc(1'h1, 12'h014, 32'h1234, 33'h0);
        acc(1'h1, 12'h024, 32'h00a5, 33'h0);
        acc(1'h0, 12'h024, 32'h0, 33'h00a5);
        acc(1'h1, 12'h018, 32'h0080, 33'h0);
        acc(1'h0, 12'h014, 32'h0, 33'ha580);
        acc(1'h0, 12'h020, 32'h0, 33'h80a5);
        acc(1'h0, 12'h028, 32'h0, 33'hff80);
        acc(1'h1, 12'h018, 32'h007f, 33'h0);
        acc(1'h0, 12'h028, 32'h0, 33'h007f);
    endtask : byte_writes
    task automatic refused;
        acc(1'h1, 12'h020, 32'hffff, 33'h1_0000_0000);
        acc(1'h1, 12'h028, 32'hffff, 33'h1_0000_0000);
        acc(1'h0, 12'h014, 32'h0, 33'ha57f);
        acc(1'h0, 12'h03c, 32'h0, 33'h1_0000_0000);
    endtask : refused
    // reset in mid-run must clear a word that holds data
    task automatic mid_reset;
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        reset_views();
    endtask : mid_reset
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        reset_views();
        byte_writes();
        refused();
        mid_reset();
        finish_test();
    end
endmodule : test_general_word_byte_views
`default_nettype wire
